// ---- phyan_defs.svh ----
// constants for the per-port negotiation configuration block
`ifndef PHYAN_DEFS_SVH
`define PHYAN_DEFS_SVH

// =====================================================
// register indices and byte addresses
`define PHYAN_IDX_BMC        12'h000
`define PHYAN_IDX_BMS        12'h001
`define PHYAN_IDX_ADV        12'h004
`define PHYAN_IDX_LPA        12'h005
`define PHYAN_IDX_EXP        12'h006
`define PHYAN_IDX_STS        12'h010
`define PHYAN_ADDR_BMC       (`PHYAN_IDX_BMC << 2)
`define PHYAN_ADDR_BMS       (`PHYAN_IDX_BMS << 2)
`define PHYAN_ADDR_ADV       (`PHYAN_IDX_ADV << 2)
`define PHYAN_ADDR_LPA       (`PHYAN_IDX_LPA << 2)
`define PHYAN_ADDR_EXP       (`PHYAN_IDX_EXP << 2)
`define PHYAN_ADDR_STS       (`PHYAN_IDX_STS << 2)

// =====================================================
// basic control fields
`define PHYAN_BMC_SPEED      13
`define PHYAN_BMC_NEGOTIATION_ENABLE_STRAP      12
`define PHYAN_BMC_RESTART    9
`define PHYAN_BMC_DUPLEX     8
`define PHYAN_BMC_RST        16'h0000

// =====================================================
// advertisement fields
`define PHYAN_ADV_NP         15
`define PHYAN_ADV_RF         13
`define PHYAN_ADV_ABIL_HI    8
`define PHYAN_ADV_ABIL_LO    5
`define PHYAN_ADV_SEL        16'h0001
`define PHYAN_ADV_RST        16'h0001
`define PHYAN_ABIL_ALL       4'hf

// =====================================================
// parallel detect partner words
`define PHYAN_LPA_PD_100     16'h0081
`define PHYAN_LPA_PD_10      16'h0021

// =====================================================
// fixed status bits
`define PHYAN_BMS_FIXED      16'h7849

// =====================================================
// timing
`define PHYAN_CLK_PERIOD_NS  4
`define PHYAN_BREAK_LINK_MS  1500
`define PHYAN_BREAK_LINK_CYC ((64'd`PHYAN_BREAK_LINK_MS * 64'd1000000) / 64'd`PHYAN_CLK_PERIOD_NS)

`endif

// ---- phyan_partner.sv ----
// remote link partner model on the cable side
`timescale 1ns/100ps
module phyan_partner (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        tx_flp_enable,
  input  wire logic        tx_quiet,
  input  wire logic        an_complete,
  input  wire logic [2:0]  mode,
  input  wire logic [15:0] word,
  input  wire logic [7:0]  dly,
  input  wire logic        link_en,
  output logic             rx_word_valid,
  output logic      [15:0] rx_word,
  output logic             rx_word_next_page,
  output logic             pd_link_100,
  output logic             pd_link_10,
  output logic             link_good
);
  logic       sent_r;
  logic       np_r;
  logic [7:0] cnt_r;

  // =====================================================
  // one base page per negotiation, then a next page if np bit set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sent_r            <= 1'b0;
      np_r              <= 1'b0;
      cnt_r             <= 8'h00;
      rx_word_valid     <= 1'b0;
      rx_word           <= 16'h0000;
      rx_word_next_page <= 1'b0;
    end else begin
      rx_word_valid     <= np_r;
      rx_word           <= np_r ? {1'b0, word[14:0]} : ~rx_word;
      rx_word_next_page <= np_r;
      np_r              <= 1'b0;
      if (tx_quiet) begin
        sent_r <= 1'b0;
        cnt_r  <= 8'h00;
      end else if (mode == 3'h0 && tx_flp_enable && !sent_r) begin
        cnt_r <= cnt_r + 8'h01;
        if (cnt_r == dly) begin
          rx_word_valid <= 1'b1;
          rx_word       <= word;
          sent_r        <= 1'b1;
          np_r          <= word[15];
        end
      end
    end
  end

  // =====================================================
  // link pulses of a non-negotiating partner, and partner link status
  assign pd_link_100       = link_en && mode[0];
  assign pd_link_10        = link_en && mode[1];
  assign link_good         = link_en && (an_complete || mode[2]);
endmodule

// ---- phyan_pkg.sv ----
// types shared by the negotiation configuration block
package phyan_pkg;

  // =====================================================
  // negotiation sequence states
  typedef enum logic [2:0] {
    ST_FORCED,
    ST_BREAK,
    ST_ABILITY,
    ST_LINK_WAIT,
    ST_LINKED
  } phyan_state_t;

  // =====================================================
  // ability nibble: bit0 10 half, bit1 10 full, bit2 100 half, bit3 100 full
  typedef logic [3:0] phyan_abil_t;

endpackage

// ---- phyan_port.sv ----
// negotiation configuration and status for one 10/100 port
//
// How it works
// - strap enable low forces mode from straps
// - strap enable high picks advertised ability set
// - straps sampled each reset into advert
// - control register write overrides straps anytime
// - advertised word sent in pulse bursts
// - resolve 100 full, 100 half, 10 full, 10 half
// - forced: speed and duplex bits choose mode
// - negotiating: speed and duplex bits ignored
// - summary register shows speed once linked
// - fixed ability bits one, T4 zero
// - status shows complete, fault, link, preamble
// - all abilities advertised when strap enable low, strap set when high, software may clear
// - partner base and next pages captured
// - parallel detect loads fixed partner word
// - expansion register shows five status flags
// - restart bit restarts negotiation
// - restart silences link for break time
// - lost link resumes negotiation
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/100ps
`include "phyan_defs.svh"
module phyan_port #(
  parameter logic [31:0] BREAK_LINK_CYCLES = 32'(`PHYAN_BREAK_LINK_CYC)
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        negotiation_enable_strap,
  input  wire logic        mode_strap_low,
  input  wire logic        mode_strap_high,
  input  wire logic        rx_word_valid,
  input  wire logic [15:0] rx_word,
  input  wire logic        rx_word_next_page,
  input  wire logic        pd_link_100,
  input  wire logic        pd_link_10,
  input  wire logic        link_good,
  output logic             tx_flp_enable,
  output logic      [15:0] tx_flp_word,
  output logic             tx_quiet,
  output logic             op_speed_100,
  output logic             op_full_duplex,
  output logic             an_complete
);

  // =====================================================
  // state
  // per-port private state
  phyan_pkg::phyan_state_t state_r;
  phyan_pkg::phyan_state_t state_nxt;
  logic [15:0] bmc_r;
  logic [15:0] adv_r;
  logic [15:0] lpa_r;
  logic        strap_done_r;
  logic        negotiation_enable_strap_d_r;
  logic        pd_fault_r;
  logic        page_rx_r;
  logic        lp_an_able_r;
  logic        lp_np_able_r;
  logic        complete_r;
  logic        pd_speed_100_r;
  logic        pd_mode_r;
  logic [31:0] brk_cnt_r;
  logic        restart_req;
  logic        access;
  logic        wr_bmc;
  logic        wr_adv;
  logic        rd_exp;
  logic [31:0] rd_data;
  logic        rd_err;
  logic [15:0] bms_word;
  logic [15:0] exp_word;
  logic [15:0] sts_word;
  logic        mode_speed;
  logic        mode_full;
  phyan_pkg::phyan_abil_t strap_abil;

  phyan_res_if res_if ();

  phyan_resolve u_resolve (
    .pclk    (pclk),
    .presetn (presetn),
    .res     (res_if.resolver)
  );

  assign res_if.local_abil   = adv_r[`PHYAN_ADV_ABIL_HI:`PHYAN_ADV_ABIL_LO];
  assign res_if.partner_abil = lpa_r[`PHYAN_ADV_ABIL_HI:`PHYAN_ADV_ABIL_LO];

  // =====================================================
  // bus decode
  assign access  = psel & penable & pready;
  assign wr_bmc  = access & pwrite & (paddr == `PHYAN_ADDR_BMC);
  assign wr_adv  = access & pwrite & (paddr == `PHYAN_ADDR_ADV);
  assign rd_exp  = access & ~pwrite & (paddr == `PHYAN_ADDR_EXP);
  assign restart_req = wr_bmc & pwdata[`PHYAN_BMC_RESTART];

  // =====================================================
  // strap decode
  // ability set from straps
  always_comb begin
    case ({mode_strap_high, mode_strap_low})
      2'b00:   strap_abil = 4'h3;
      2'b01:   strap_abil = 4'hc;
      2'b10:   strap_abil = 4'h5;
      default: strap_abil = 4'hf;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_done_r <= 1'b0;
    end else begin
      strap_done_r <= 1'b1;
    end
  end

  // =====================================================
  // basic control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bmc_r <= `PHYAN_BMC_RST;
    end else if (!strap_done_r) begin
      bmc_r                     <= `PHYAN_BMC_RST;
      bmc_r[`PHYAN_BMC_NEGOTIATION_ENABLE_STRAP]   <= negotiation_enable_strap;
      bmc_r[`PHYAN_BMC_SPEED]   <= mode_strap_high;
      bmc_r[`PHYAN_BMC_DUPLEX]  <= mode_strap_low;
    end else if (wr_bmc) begin
      bmc_r                     <= pwdata[15:0];
      bmc_r[`PHYAN_BMC_RESTART] <= 1'b0;
    end
  end

  // =====================================================
  // advertisement register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adv_r <= `PHYAN_ADV_RST;
    end else if (!strap_done_r) begin
      adv_r <= `PHYAN_ADV_SEL;
      adv_r[`PHYAN_ADV_ABIL_HI:`PHYAN_ADV_ABIL_LO] <=
        negotiation_enable_strap ? strap_abil : `PHYAN_ABIL_ALL;
    end else if (wr_adv) begin
      adv_r <= pwdata[15:0];
    end
  end

  // =====================================================
  // enable bit history
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      negotiation_enable_strap_d_r <= 1'b0;
    end else begin
      negotiation_enable_strap_d_r <= bmc_r[`PHYAN_BMC_NEGOTIATION_ENABLE_STRAP];
    end
  end

  // =====================================================
  // sequence
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      phyan_pkg::ST_FORCED: begin
        // only a fresh enable starts negotiation
        if (strap_done_r && bmc_r[`PHYAN_BMC_NEGOTIATION_ENABLE_STRAP] && !negotiation_enable_strap_d_r) begin
          state_nxt = phyan_pkg::ST_BREAK;
        end
      end
      phyan_pkg::ST_BREAK: begin
        if (brk_cnt_r >= BREAK_LINK_CYCLES - 32'h1) begin
          state_nxt = phyan_pkg::ST_ABILITY;
        end
      end
      phyan_pkg::ST_ABILITY: begin
        if (rx_word_valid && !rx_word_next_page) begin
          state_nxt = phyan_pkg::ST_LINK_WAIT;
        end else if (pd_link_100 ^ pd_link_10) begin
          state_nxt = phyan_pkg::ST_LINK_WAIT;
        end
      end
      phyan_pkg::ST_LINK_WAIT: begin
        if (complete_r && link_good) begin
          state_nxt = phyan_pkg::ST_LINKED;
        end
      end
      default: begin
        if (!link_good) begin
          state_nxt = phyan_pkg::ST_ABILITY;
        end
      end
    endcase
    if (state_r != phyan_pkg::ST_FORCED && restart_req) begin
      state_nxt = phyan_pkg::ST_BREAK;
    end
    if (strap_done_r && !bmc_r[`PHYAN_BMC_NEGOTIATION_ENABLE_STRAP]) begin
      state_nxt = phyan_pkg::ST_FORCED;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= phyan_pkg::ST_FORCED;
    end else if (!strap_done_r) begin
      state_r <= negotiation_enable_strap ? phyan_pkg::ST_ABILITY : phyan_pkg::ST_FORCED;
    end else begin
      state_r <= state_nxt;
    end
  end

  // =====================================================
  // break link timer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brk_cnt_r <= 32'h0;
    end else if (state_r == phyan_pkg::ST_BREAK && state_nxt == phyan_pkg::ST_BREAK) begin
      brk_cnt_r <= brk_cnt_r + 32'h1;
    end else begin
      brk_cnt_r <= 32'h0;
    end
  end

  // =====================================================
  // partner word capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lpa_r          <= 16'h0000;
      lp_an_able_r   <= 1'b0;
      lp_np_able_r   <= 1'b0;
      pd_speed_100_r <= 1'b0;
      pd_mode_r      <= 1'b0;
    end else if (state_r == phyan_pkg::ST_BREAK) begin
      lpa_r          <= 16'h0000;
      lp_an_able_r   <= 1'b0;
      lp_np_able_r   <= 1'b0;
      pd_mode_r      <= 1'b0;
    end else if (state_r == phyan_pkg::ST_ABILITY && rx_word_valid) begin
      lpa_r        <= rx_word;
      lp_an_able_r <= 1'b1;
      lp_np_able_r <= rx_word[`PHYAN_ADV_NP];
      pd_mode_r    <= 1'b0;
    end else if (state_r == phyan_pkg::ST_ABILITY && (pd_link_100 ^ pd_link_10)) begin
      lpa_r          <= pd_link_100 ? `PHYAN_LPA_PD_100 : `PHYAN_LPA_PD_10;
      lp_an_able_r   <= 1'b0;
      pd_speed_100_r <= pd_link_100;
      pd_mode_r      <= 1'b1;
    end else if (state_r == phyan_pkg::ST_LINK_WAIT && rx_word_valid && rx_word_next_page) begin
      lpa_r <= rx_word;
    end
  end

  // =====================================================
  // completion
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      complete_r <= 1'b0;
    end else if (state_r == phyan_pkg::ST_LINK_WAIT) begin
      complete_r <= pd_mode_r | res_if.res_valid;
    end else if (state_r != phyan_pkg::ST_LINKED) begin
      complete_r <= 1'b0;
    end
  end

  // =====================================================
  // sticky expansion flags, set wins over read clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pd_fault_r <= 1'b0;
    end else if (state_r == phyan_pkg::ST_ABILITY && pd_link_100 && pd_link_10) begin
      pd_fault_r <= 1'b1;
    end else if (rd_exp) begin
      pd_fault_r <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      page_rx_r <= 1'b0;
    end else if (rx_word_valid && state_r != phyan_pkg::ST_FORCED) begin
      page_rx_r <= 1'b1;
    end else if (rd_exp) begin
      page_rx_r <= 1'b0;
    end
  end

  // =====================================================
  // operating mode
  always_comb begin
    if (!bmc_r[`PHYAN_BMC_NEGOTIATION_ENABLE_STRAP]) begin
      mode_speed = bmc_r[`PHYAN_BMC_SPEED];
      mode_full  = bmc_r[`PHYAN_BMC_DUPLEX];
    end else if (pd_mode_r) begin
      mode_speed = pd_speed_100_r;
      mode_full  = 1'b0;
    end else begin
      mode_speed = res_if.res_speed_100;
      mode_full  = res_if.res_full;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_speed_100   <= 1'b0;
      op_full_duplex <= 1'b0;
      an_complete    <= 1'b0;
    end else begin
      op_speed_100   <= mode_speed;
      op_full_duplex <= mode_full;
      an_complete    <= complete_r;
    end
  end

  // =====================================================
  // line side
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_flp_enable <= 1'b0;
      tx_flp_word   <= 16'h0000;
      tx_quiet      <= 1'b1;
    end else begin
      tx_flp_enable <= (state_r == phyan_pkg::ST_ABILITY) ||
                       (state_r == phyan_pkg::ST_LINK_WAIT && !pd_mode_r);
      tx_flp_word   <= adv_r;
      tx_quiet      <= (state_r == phyan_pkg::ST_BREAK) || !strap_done_r;
    end
  end

  // =====================================================
  // read words
  // fixed ability bits
  assign bms_word = `PHYAN_BMS_FIXED | {10'h000, complete_r, lpa_r[`PHYAN_ADV_RF], 1'b0,
                                        link_good, 2'b00};
  assign exp_word = {11'h000, pd_fault_r, lp_np_able_r, adv_r[`PHYAN_ADV_NP], page_rx_r,
                     lp_an_able_r};
  assign sts_word = {11'h000, complete_r, 1'b0, op_full_duplex,
                     (state_r == phyan_pkg::ST_LINKED || !bmc_r[`PHYAN_BMC_NEGOTIATION_ENABLE_STRAP]) &
                     link_good & !op_speed_100, link_good};

  always_comb begin
    rd_data = 32'h0;
    rd_err  = 1'b0;
    if (paddr == `PHYAN_ADDR_BMC) begin
      rd_data = {16'h0000, bmc_r};
    end else if (paddr == `PHYAN_ADDR_BMS) begin
      rd_data = {16'h0000, bms_word};
    end else if (paddr == `PHYAN_ADDR_ADV) begin
      rd_data = {16'h0000, adv_r};
    end else if (paddr == `PHYAN_ADDR_LPA) begin
      rd_data = {16'h0000, lpa_r};
    end else if (paddr == `PHYAN_ADDR_EXP) begin
      rd_data = {16'h0000, exp_word};
    end else if (paddr == `PHYAN_ADDR_STS) begin
      rd_data = {16'h0000, sts_word};
    end else begin
      rd_err  = 1'b1;
    end
  end

  // =====================================================
  // bus answer, one wait cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else if (psel && penable && !pready && strap_done_r) begin
      pready  <= 1'b1;
      pslverr <= rd_err;
      prdata  <= pwrite ? 32'h0 : rd_data;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end
  end

endmodule

// ---- phyan_port_props.sv ----
// concurrent checks on the ports of one negotiation port
`timescale 1ns/100ps
`include "phyan_defs.svh"
module phyan_port_props #(
  parameter logic [31:0] BREAK_LINK_CYCLES = 32'h10
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [11:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        tx_flp_enable,
  input wire logic [15:0] tx_flp_word,
  input wire logic        tx_quiet,
  input wire logic        op_speed_100,
  input wire logic        op_full_duplex
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic        done;
  logic [31:0] quiet_cnt_r;
  logic        armed_r;
  assign done = psel && penable && pready;

  // =====================================================
  // helper counters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) quiet_cnt_r <= 32'h0;
    else if (tx_quiet) quiet_cnt_r <= quiet_cnt_r + 32'h1;
    else quiet_cnt_r <= 32'h0;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) armed_r <= 1'b0;
    else if (done && pwrite && paddr == `PHYAN_ADDR_BMC && pwdata[12] && pwdata[9]) armed_r <= 1'b1;
    else if (!tx_quiet && quiet_cnt_r != 32'h0) armed_r <= 1'b0;
  end

  // =====================================================
  // sequences
  sequence s_access;
    $rose(psel && penable);
  endsequence
  sequence s_restart_wr;
    done && pwrite && paddr == `PHYAN_ADDR_BMC && pwdata[12] && pwdata[9];
  endsequence
  sequence s_forced_wr;
    done && pwrite && paddr == `PHYAN_ADDR_BMC && !pwdata[12];
  endsequence
  sequence s_adv_wr;
    done && pwrite && paddr == `PHYAN_ADDR_ADV;
  endsequence

  // =====================================================
  // properties
  AST_ONE_WAIT:
    assert property (s_access |=> pready) else $error("ready not one cycle after access");
  AST_READY_PULSE:
    assert property (pready |=> !pready) else $error("ready longer than one cycle");
  AST_STATUS_FIXED:
    assert property (done && !pwrite && paddr == `PHYAN_ADDR_BMS |->
      (prdata[15:0] & 16'hf849) == 16'h7849) else $error("fixed status bits wrong");
  AST_RESTART_READS0:
    assert property (done && !pwrite && paddr == `PHYAN_ADDR_BMC |-> !prdata[9])
      else $error("restart bit reads one");
  AST_BREAK_START:
    assert property (s_restart_wr |-> ##[1:3] tx_quiet) else $error("restart gave no break");
  AST_QUIET_SILENT:
    assert property (tx_quiet |-> !tx_flp_enable) else $error("bursts during break");
  AST_BREAK_LEN:
    assert property ($fell(tx_quiet) && armed_r |-> quiet_cnt_r + 32'h1 >= BREAK_LINK_CYCLES
      && quiet_cnt_r <= BREAK_LINK_CYCLES + 32'h1) else $error("break length wrong");
  AST_FLP_WORD:
    assert property (s_adv_wr |=> ##1 tx_flp_word[8:5] == $past(pwdata[8:5], 2))
      else $error("burst word not advert");
  AST_FORCED_MODE:
    assert property (s_forced_wr |=> ##1 op_speed_100 == $past(pwdata[13], 2)
      && op_full_duplex == $past(pwdata[8], 2)) else $error("forced mode wrong");
endmodule

bind phyan_port phyan_port_props #(.BREAK_LINK_CYCLES(BREAK_LINK_CYCLES)) u_props (
  .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
  .pslverr, .tx_flp_enable, .tx_flp_word, .tx_quiet, .op_speed_100, .op_full_duplex
);

// ---- phyan_port_tb_top.sv ----
// register-level testbench for one negotiation port
`timescale 1ns/100ps
`include "phyan_defs.svh"
module phyan_port_tb_top;
  localparam logic [3:0]  ABIL [4]  = '{4'h3, 4'hc, 4'h5, 4'hf};
  localparam logic [13:0] CASES [8] = '{
    {3'h0, 4'hf, 4'h8, 1'h0, 1'h1, 1'h1}, {3'h0, 4'hf, 4'h4, 1'h1, 1'h1, 1'h0},
    {3'h0, 4'hf, 4'h2, 1'h0, 1'h0, 1'h1}, {3'h0, 4'hf, 4'h1, 1'h0, 1'h0, 1'h0},
    {3'h0, 4'hf, 4'h6, 1'h1, 1'h1, 1'h0}, {3'h0, 4'h3, 4'hf, 1'h0, 1'h0, 1'h1},
    {3'h1, 4'hf, 4'h0, 1'h0, 1'h1, 1'h0}, {3'h2, 4'hf, 4'h0, 1'h0, 1'h0, 1'h0}};
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [31:0] pwdata  = 32'h0;
  logic [2:0]  strap   = 3'h7;
  logic [2:0]  p_mode  = 3'h0;
  logic [15:0] p_word  = 16'h0000;
  logic [7:0]  p_dly   = 8'h03;
  logic        p_link  = 1'b1;
  logic [31:0] prdata, q;
  logic [15:0] rx_w, flp_w, lpa;
  logic [13:0] c;
  logic        pready, pslverr, e, rx_v, rx_np, pd100, pd10, lgood, flp_en, quiet, spd, full, done;
  int          failures = 0;
  int          n_checks = 0;

  always #2 pclk = ~pclk;

  phyan_port #(.BREAK_LINK_CYCLES(32'h10)) u_dut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .negotiation_enable_strap(strap[2]), .mode_strap_high(strap[1]), .mode_strap_low(strap[0]),
    .rx_word_valid(rx_v), .rx_word(rx_w), .rx_word_next_page(rx_np), .pd_link_100(pd100),
    .pd_link_10(pd10), .link_good(lgood), .tx_flp_enable(flp_en), .tx_flp_word(flp_w),
    .tx_quiet(quiet), .op_speed_100(spd), .op_full_duplex(full), .an_complete(done));
  phyan_partner u_partner (
    .pclk(pclk), .presetn(presetn), .tx_flp_enable(flp_en), .tx_quiet(quiet),
    .an_complete(done), .mode(p_mode), .word(p_word), .dly(p_dly), .link_en(p_link),
    .rx_word_valid(rx_v), .rx_word(rx_w), .rx_word_next_page(rx_np), .pd_link_100(pd100),
    .pd_link_10(pd10), .link_good(lgood));

  // =====================================================
  // tasks
  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] m,
                    input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(nm, q & m, exp);
  endtask
  task automatic wait_for(ref logic s, input logic lvl, input string nm);
    int n;
    n = 0;
    while (s !== lvl && n < 300) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 300) check(nm, {31'h0, s}, {31'h0, lvl});
  endtask
  task automatic rst(input logic [2:0] s);
    presetn <= 1'b0;
    strap   <= s;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
  endtask
  task automatic end_of_test();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // =====================================================
  // tests
  initial begin
    for (int s = 0; s < 8; s++) begin
      rst(3'(s));
      rd("advert", `PHYAN_ADDR_ADV, 32'hffff, {23'h0, s[2] ? ABIL[s[1:0]] : 4'hf, 5'h01});
      rd("control", `PHYAN_ADDR_BMC, 32'h3100, {18'h0, s[1], s[2], 3'h0, s[0], 8'h00});
      if (!s[2]) check("forced mode", {30'h0, spd, full}, {30'h0, s[1], s[0]});
    end
    rd("status", `PHYAN_ADDR_BMS, 32'hf86d, 32'h7849);
    apb(1'b0, 12'h008, 32'h0);
    check("unmapped", {q[30:0], e}, 32'h1);
    apb(1'b1, `PHYAN_ADDR_LPA, 32'hffff);
    rd("partner ro", `PHYAN_ADDR_LPA, 32'hffff, 32'h0);
    for (int i = 0; i < 8; i++) begin
      c = CASES[i];
      lpa = c[13:11] == 3'h1 ? 16'h0081 : c[13:11] == 3'h2 ? 16'h0021 : {7'h0, c[6:3], 5'h01};
      p_mode <= c[13:11];
      p_word <= {7'h0, c[6:3], 5'h01};
      p_dly  <= c[2] ? 8'h14 : 8'h03;
      apb(1'b1, `PHYAN_ADDR_ADV, {23'h0, c[10:7], 5'h01});
      apb(1'b1, `PHYAN_ADDR_BMC, 32'h1200);
      wait_for(quiet, 1'b1, "break");
      wait_for(quiet, 1'b0, "break end");
      wait_for(done, 1'b1, "complete");
      check("resolved", {30'h0, spd, full}, {30'h0, c[1:0]});
      rd("partner", `PHYAN_ADDR_LPA, 32'hffff, {16'h0, lpa});
      rd("summary", `PHYAN_ADDR_STS, 32'h17, {27'h0, 2'h2, c[0], ~c[1], 1'h1});
      rd("status", `PHYAN_ADDR_BMS, 32'h24, 32'h24);
      rd("expansion", `PHYAN_ADDR_EXP, 32'h3, {30'h0, {2{c[13:11] == 3'h0}}});
    end
    p_link <= 1'b0;
    wait_for(done, 1'b0, "link loss");
    wait_for(flp_en, 1'b1, "resume");
    check("no break", {31'h0, quiet}, 32'h0);
    p_link <= 1'b1;
    p_mode <= 3'h3;
    apb(1'b1, `PHYAN_ADDR_BMC, 32'h1200);
    wait_for(quiet, 1'b1, "break");
    wait_for(quiet, 1'b0, "break end");
    repeat (4) @(posedge pclk);
    rd("pd fault", `PHYAN_ADDR_EXP, 32'h10, 32'h10);
    p_mode <= 3'h4;
    apb(1'b1, `PHYAN_ADDR_BMC, 32'h2000);
    repeat (2) @(posedge pclk);
    check("forced 100 half", {30'h0, spd, full}, 32'h2);
    apb(1'b1, `PHYAN_ADDR_BMC, 32'h0300);
    repeat (4) @(posedge pclk);
    check("forced restart", {28'h0, spd, full, quiet, flp_en}, 32'h4);
    rd("summary forced", `PHYAN_ADDR_STS, 32'h6, 32'h6);
    p_mode <= 3'h0;
    p_word <= 16'h8021;
    apb(1'b1, `PHYAN_ADDR_BMC, 32'h3100);
    wait_for(quiet, 1'b1, "break");
    wait_for(quiet, 1'b0, "break end");
    wait_for(done, 1'b1, "complete");
    check("bits ignored", {30'h0, spd, full}, 32'h0);
    rd("next page", `PHYAN_ADDR_LPA, 32'hffff, 32'h0021);
    rd("np able", `PHYAN_ADDR_EXP, 32'h8, 32'h8);
    end_of_test();
  end

  initial begin
    #40000;
    failures++;
    end_of_test();
  end
endmodule

// ---- phyan_res_if.sv ----
// carrier between the port logic and the mode resolver
`timescale 1ns/100ps
interface phyan_res_if;
  phyan_pkg::phyan_abil_t local_abil;
  phyan_pkg::phyan_abil_t partner_abil;
  logic                   res_valid;
  logic                   res_speed_100;
  logic                   res_full;

  modport owner    (output local_abil, output partner_abil,
                    input res_valid, input res_speed_100, input res_full);
  modport resolver (input local_abil, input partner_abil,
                    output res_valid, output res_speed_100, output res_full);
endinterface

// ---- phyan_resolve.sv ----
// picks the best common mode of the local and partner ability sets
`timescale 1ns/100ps
module phyan_resolve (
  input  wire logic   pclk,
  input  wire logic   presetn,
  phyan_res_if.resolver res
);

  phyan_pkg::phyan_abil_t common;

  assign common = res.local_abil & res.partner_abil;

  // =====================================================
  // priority pick
  // fixed resolution order
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res.res_valid     <= 1'b0;
      res.res_speed_100 <= 1'b0;
      res.res_full      <= 1'b0;
    end else if (common[3]) begin
      res.res_valid     <= 1'b1;
      res.res_speed_100 <= 1'b1;
      res.res_full      <= 1'b1;
    end else if (common[2]) begin
      res.res_valid     <= 1'b1;
      res.res_speed_100 <= 1'b1;
      res.res_full      <= 1'b0;
    end else if (common[1]) begin
      res.res_valid     <= 1'b1;
      res.res_speed_100 <= 1'b0;
      res.res_full      <= 1'b1;
    end else begin
      res.res_valid     <= common[0];
      res.res_speed_100 <= 1'b0;
      res.res_full      <= 1'b0;
    end
  end

endmodule
